// ===== bench/rbc_partner.sv
// Far-side model: board reset circuit and program memory for vector fetch
// Assumes fetch_req is sampled on the rising edge of clk
`timescale 1ns/1ps
module rbc_partner (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        push,
  input  wire logic        fetch_req,
  input  wire logic [23:0] fetch_addr,
  input  wire logic [15:0] vector,
  output logic             reset_n,
  output logic [7:0]       fetch_data
);
  logic [3:0] hold;

  // ==========================================================
  // Reset pin held low after power-on and while push is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold       <= 4'h6;
      fetch_data <= 8'h5a;
    end else begin
      if (hold != 4'h0)
        hold <= hold - 4'h1;
      // Byte one cycle after request, a moving pattern otherwise
      if (fetch_req)
        fetch_data <= fetch_addr[0] ? vector[15:8] : vector[7:0];
      else
        fetch_data <= ~fetch_data ^ 8'h3c;
    end
  end

  assign reset_n = (hold == 4'h0) && !push;
endmodule

// ===== bench/test_rbc_regs.sv
// Self-checking bench for the reset sequencer and config registers
// Assumes rbc_pkg, rbc_regs and rbc_partner are compiled first
`timescale 1ns/1ps
module test_rbc_regs;
  localparam int unsigned TICKS = 8;
  logic        clk = 1'b0, rst = 1'b1, push = 1'b0, slow_tick = 1'b0;
  logic        bus_wr = 1'b0, bus_rd = 1'b0, ext_access = 1'b0;
  logic        t3_end = 1'b0, half_tick = 1'b0, shared_input_pin = 1'b1;
  logic        release_ack_n = 1'b1, port_r51 = 1'b0;
  logic [23:0] bus_addr = 24'h0, fetch_addr;
  logic [7:0]  bus_wdata = 8'h0, fetch_data, bus_rdata, cpu_flags;
  logic [7:0]  new_code_bank, code_bank, expand_page, expand_page_x;
  logic [7:0]  expand_page_y, stack_page, d, v;
  logic [3:0]  port_r3 = 4'h0, strobe_pin, ext_strobe;
  logic [15:0] vector = 16'h0, pc, a16;
  logic [1:0]  bus_mode, voltage_mode, ext_mode;
  logic        reset_n, bus_hit, cpu_hold, cpu_run, fetch_req, bus_wait;
  logic        bus_release_request_n, shared_output_pin, cpu_clock_select;
  logic        fast_osc_on, int_blocked;
  int          fails = 0, n_tests = 0, cyc = 0, n;
  int          modes[3] = '{0, 2, 3};

  rbc_regs #(.EXT_ROM(1'b0), .SETTLE_TICKS(TICKS)) i_rbc_regs (.*);
  rbc_partner i_rbc_partner (.*);
  // External-rom variant, only its mode and strobe pins are watched
  rbc_regs #(.EXT_ROM(1'b1), .SETTLE_TICKS(TICKS)) i_rbc_regs_ext (
    .*, .bus_hit(), .bus_rdata(), .cpu_hold(), .cpu_run(), .fetch_req(),
    .fetch_addr(), .pc(), .cpu_flags(), .new_code_bank(), .code_bank(),
    .expand_page(), .expand_page_x(), .expand_page_y(),
    .bus_mode(ext_mode), .stack_page(), .strobe_pin(ext_strobe),
    .bus_release_request_n(), .shared_output_pin(), .bus_wait(),
    .cpu_clock_select(), .fast_osc_on(), .voltage_mode(),
    .int_blocked());

  always #25 clk = ~clk;

  // ==========================================================
  // Slow oscillator ticks and run limit
  always @(posedge clk) begin
    cyc++;
    #5;
    slow_tick = (cyc % 4 == 0);
    if (cyc > 20000) begin
      fails++;
      conclude();
    end
  end

  // ==========================================================
  // Helpers
  task automatic step(int k = 1);
    repeat (k) @(posedge clk);
    #5;
  endtask

  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [23:0] a, logic [7:0] x);
    bus_addr = a;
    bus_wdata = x;
    bus_wr = 1'b1;
    step();
    bus_wr = 1'b0;
    step();
  endtask

  task automatic rd(logic [23:0] a, output logic [7:0] x);
    bus_addr = a;
    bus_rd = 1'b1;
    step();
    x = bus_rdata;
    bus_rd = 1'b0;
    step();
  endtask

  function automatic logic [1:0] exp_mode(logic [1:0] f);
    return (f == 2'b01) ? 2'b00 : f;
  endfunction

  function automatic logic [3:0] exp_strobe(logic [1:0] m, logic [3:0] e,
                                           logic [3:0] p);
    return (m == 2'b00) ? p : (e | p);
  endfunction

  function automatic int exp_wait(logic [2:0] wt, logic f, logic x);
    return (f && x) ? 2 * wt : 0;
  endfunction

  // Active-low 64K strobes from the range size of each strobe
  function automatic logic [3:0] exp_ce(logic [15:0] a, logic [1:0] sz);
    int k;
    k = (sz == 2'b11) ? 0 : (sz == 2'b10) ? a / 16'h8000 :
        (sz == 2'b01) ? a / 16'h4000 : a / 16'h2000;
    return (a > 16'hefff || k > 3) ? 4'hf : ~(4'h1 << k);
  endfunction

  // Waits for the vector fetch and follows it to the run state
  task automatic fetch_seq(int lo, int hi);
    int k;
    k = 0;
    check("held", cpu_hold, 1'b1);
    while (!fetch_req && k < 200) begin
      step();
      k++;
    end
    check("start delay", (k >= lo) && (k <= hi), 1'b1);
    check("vector lo addr", fetch_addr, rbc_pkg::VEC_LO_ADDR);
    step();
    check("vector hi addr", fetch_addr, rbc_pkg::VEC_HI_ADDR);
    step(2);
    check("run", {cpu_run, cpu_hold}, 2'b10);
    check("pc", pc, vector);
    check("code bank", code_bank, 8'h01);
  endtask

  task automatic wait_run(logic [2:0] wt, logic f, logic x);
    wr(rbc_pkg::ADDR_SYS_CTRL, {1'b0, wt, f, 3'b100});
    ext_access = x;
    t3_end = 1'b1;
    step();
    t3_end = 1'b0;
    check("wait rise", bus_wait, exp_wait(wt, f, x) != 0);
    n = 0;
    while (bus_wait === 1'b1 && n < 20) begin
      half_tick = 1'b1;
      step();
      half_tick = 1'b0;
      step();
      n++;
    end
    check("wait length", n, exp_wait(wt, f, x));
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h211a));
    vector = 16'($urandom);
    step(2);
    rst = 1'b0;
    check("flags", cpu_flags, 8'hc0);
    check("new bank", new_code_bank, 8'h01);
    check("pages", {expand_page, expand_page_x, expand_page_y}, 0);
    check("blocked", int_blocked, 1'b1);
    check("ext mode", ext_mode, 2'b11);
    fetch_seq(30, 60);
    $display("power-on test done");

    rd(rbc_pkg::ADDR_BUS_CFG, d);
    check("cfg reset", d, 8'h30);
    rd(rbc_pkg::ADDR_STACK_PG, d);
    check("stack reset", d, 8'h00);
    rd(rbc_pkg::ADDR_SYS_CTRL, d);
    check("sys reset", d, 8'h00);
    check("hit", bus_hit, 1'b1);
    rd(24'h00ff03, d);
    check("miss data", d, 8'h00);
    check("miss", bus_hit, 1'b0);
    wr(rbc_pkg::ADDR_STACK_PG, 8'h27);
    check("blocked one", int_blocked, 1'b1);
    wr(rbc_pkg::ADDR_BUS_CFG, 8'hca);
    check("unblocked", int_blocked, 1'b0);
    $display("register test done");

    foreach (modes[i]) begin
      v = {2'(modes[i]), 2'b11, 4'($urandom)};
      port_r3 = 4'($urandom);
      wr(rbc_pkg::ADDR_BUS_CFG, v);
      check("mode", bus_mode, exp_mode(v[7:6]));
      check("ext mode", ext_mode, v[7] ? v[7:6] : 2'b01);
      check("strobe", strobe_pin,
            exp_strobe(exp_mode(v[7:6]), v[3:0], port_r3));
      check("stack page", stack_page, v[7] ? 8'h27 : 8'h00);
      rd(rbc_pkg::ADDR_BUS_CFG, d);
      check("cfg read", d, v);
    end
    ext_access = 1'b1;
    for (int z = 0; z < 8; z++) begin
      wr(rbc_pkg::ADDR_BUS_CFG, {2'b00, 2'(z), 4'hf});
      a16 = z[2] ? 16'($urandom) : 16'hefff + 16'(z[0]);
      bus_addr = {8'h00, a16};
      step();
      check("ext strobe", ext_strobe, exp_ce(a16, 2'(z)));
      check("single port", strobe_pin, port_r3);
    end
    ext_access = 1'b0;
    $display("mode test done");

    for (int i = 0; i < 4; i++) begin
      v = {i[0], 7'($urandom)};
      shared_input_pin = 1'($urandom);
      release_ack_n = 1'($urandom);
      port_r51 = 1'($urandom);
      wr(rbc_pkg::ADDR_SYS_CTRL, v);
      check("release req", bus_release_request_n,
            v[7] ? shared_input_pin : 1'b1);
      check("release out", shared_output_pin,
            v[7] ? release_ack_n : port_r51);
      check("sys bits", {cpu_clock_select, fast_osc_on, voltage_mode},
            v[3:0]);
    end
    $display("release test done");

    for (int w = 0; w < 8; w++)
      wait_run(3'(w), 1'b1, 1'b1);
    wait_run(3'h7, 1'b0, 1'b1);
    wait_run(3'($urandom) | 3'h1, 1'b1, 1'b0);
    $display("wait test done");

    push = 1'b1;
    step(2);
    wr(rbc_pkg::ADDR_SYS_CTRL, 8'hff);
    check("pin hold", {cpu_hold, int_blocked}, 2'b11);
    check("flags again", cpu_flags, 8'hc0);
    vector = 16'($urandom);
    push = 1'b0;
    fetch_seq(1, 4);
    rd(rbc_pkg::ADDR_SYS_CTRL, d);
    check("sys wiped", d, 8'h00);
    rd(rbc_pkg::ADDR_BUS_CFG, d);
    check("cfg wiped", d, 8'h30);
    $display("pin reset test done");
    conclude();
  end
endmodule

// ===== design/rbc_pkg.sv
// Shared constants and types for the reset sequencer and config registers
// Assumes a 24-bit CPU address bus and 8-bit data bus
package rbc_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [23:0] ADDR_BUS_CFG   = 24'h00ff00;
  localparam logic [23:0] ADDR_STACK_PG  = 24'h00ff01;
  localparam logic [23:0] ADDR_SYS_CTRL  = 24'h00ff02;
  localparam logic [23:0] VEC_LO_ADDR    = 24'h000000;
  localparam logic [23:0] VEC_HI_ADDR    = 24'h000001;

  // ==========================================================
  // Reset values
  localparam logic [7:0] BUS_CFG_RST_INT = 8'h30;
  localparam logic [7:0] BUS_CFG_RST_EXT = 8'hf1;
  localparam logic [7:0] STACK_PG_RST    = 8'h00;
  localparam logic [7:0] SYS_CTRL_RST    = 8'h00;
  localparam logic [7:0] FLAGS_RST       = 8'hc0;
  localparam logic [7:0] NB_RST          = 8'h01;
  localparam logic [7:0] PAGE_RST        = 8'h00;
  localparam logic [7:0] READ_MISS       = 8'h00;

  // ==========================================================
  // Field positions
  // Bus config: mode [7:6], strobe size [5:4], strobe enables [3:0]
  localparam int BSM_HI  = 7;
  localparam int BSM_LO  = 6;
  localparam int CES_HI  = 5;
  localparam int CES_LO  = 4;
  localparam int CE_MSB  = 3;
  localparam int CE_LSB  = 0;
  // System control
  localparam int REL_EN  = 7;
  localparam int WT_MSB  = 6;
  localparam int WT_LSB  = 4;
  localparam int CLK_SEL = 3;
  localparam int OSC_ON  = 2;
  localparam int VDC_HI  = 1;
  localparam int VDC_LO  = 0;
  // Flags: i1 i0 u d n v c z from msb down
  localparam logic [7:0] STACK_PG_MAX = 8'h27;

  // ==========================================================
  // Timing
  localparam int unsigned SETTLE_PERIODS = 8192;

  // ==========================================================
  // Strobe size codes and 64K decode limits
  localparam logic [1:0]  CES_64K  = 2'b11;
  localparam logic [1:0]  CES_32K  = 2'b10;
  localparam logic [1:0]  CES_16K  = 2'b01;
  localparam logic [1:0]  CES_8K   = 2'b00;
  localparam logic [15:0] K64_TOP  = 16'hefff;
  localparam logic [15:0] K32_TOP  = 16'h7fff;

  typedef enum logic [1:0] {
    RBC_SINGLE = 2'b00,
    RBC_K64    = 2'b01,
    RBC_MIN512 = 2'b10,
    RBC_MAX512 = 2'b11
  } rbc_mode_t;

  typedef enum logic [2:0] {
    RBC_HOLD   = 3'b000,
    RBC_SETTLE = 3'b001,
    RBC_VEC0   = 3'b011,
    RBC_VEC1   = 3'b010,
    RBC_VLOAD  = 3'b110,
    RBC_RUN    = 3'b111
  } rbc_state_t;

  // Mode field decode; 01 is 64K only on the external-rom variant
  function automatic rbc_mode_t rbc_mode_f(input logic [1:0] f,
                                           input logic       ext);
    case (f)
      2'b11:   rbc_mode_f = RBC_MAX512;
      2'b10:   rbc_mode_f = RBC_MIN512;
      2'b01:   rbc_mode_f = ext ? RBC_K64 : RBC_SINGLE;
      default: rbc_mode_f = ext ? RBC_K64 : RBC_SINGLE;
    endcase
  endfunction

  // 64K-mode strobe select, active high
  function automatic logic [3:0] rbc_strobe_f(input logic [15:0] a,
                                              input logic [1:0]  sz);
    rbc_strobe_f = 4'h0;
    case (sz)
      CES_64K: if (a <= K64_TOP) rbc_strobe_f = 4'h1;
      CES_32K: begin
        if (a <= K32_TOP) rbc_strobe_f = 4'h1;
        else if (a <= K64_TOP) rbc_strobe_f = 4'h2;
      end
      CES_16K: if (a <= K64_TOP) rbc_strobe_f = 4'h1 << a[15:14];
      default: if (a <= K32_TOP) rbc_strobe_f = 4'h1 << a[14:13];
    endcase
  endfunction

endpackage

// ===== design/rbc_regs.sv
// Reset sequencer with CPU reset values and system config registers
// Assumes a synchronous byte memory answering fetch_req one cycle later
// What this block does
// - Reset pin low holds CPU and peripherals
// - Release fetches vector bytes 000000H, 000001H
// - Power-on release waits 8192 slow periods
// - Flags clear, both interrupt masks set
// - New bank 01H, expand pages 00H
// - Vector to PC, code bank gets 01H
// - Reset leaves RAM and display memory alone
// - Config registers sit in memory space
// - Each register takes its reset value
// - Enable bits route strobes, single chip ports
// - 64K mode size field sets strobe ranges
// - Stack page zero unless 512K mode
// - Release enable repurposes two port pins
// - Wait field inserts twice value states
// - Interrupts blocked until both registers written
// - Waits only external, fast clock, after T3
// - One wait state is half CPU clock
`timescale 1ns/1ps
module rbc_regs #(
  parameter bit          EXT_ROM      = 1'b0,
  parameter int unsigned SETTLE_TICKS = rbc_pkg::SETTLE_PERIODS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        reset_n,
  input  wire logic        slow_tick,
  input  wire logic [7:0]  fetch_data,
  input  wire logic [23:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        ext_access,
  input  wire logic        t3_end,
  input  wire logic        half_tick,
  input  wire logic [3:0]  port_r3,
  input  wire logic        shared_input_pin,
  input  wire logic        release_ack_n,
  input  wire logic        port_r51,
  output logic             bus_hit,
  output logic [7:0]       bus_rdata,
  output logic             cpu_hold,
  output logic             cpu_run,
  output logic             fetch_req,
  output logic [23:0]      fetch_addr,
  output logic [15:0]      pc,
  output logic [7:0]       cpu_flags,
  output logic [7:0]       new_code_bank,
  output logic [7:0]       code_bank,
  output logic [7:0]       expand_page,
  output logic [7:0]       expand_page_x,
  output logic [7:0]       expand_page_y,
  output logic [1:0]       bus_mode,
  output logic [7:0]       stack_page,
  output logic [3:0]       strobe_pin,
  output logic             bus_release_request_n,
  output logic             shared_output_pin,
  output logic             bus_wait,
  output logic             cpu_clock_select,
  output logic             fast_osc_on,
  output logic [1:0]       voltage_mode,
  output logic             int_blocked
);

  typedef struct packed {
    rbc_pkg::rbc_state_t state;
    logic                por;
    logic [7:0]          flags;
    logic [7:0]          nb;
    logic [7:0]          cb;
    logic [7:0]          ep;
    logic [7:0]          xp;
    logic [7:0]          yp;
    logic [15:0]         pc;
    logic [7:0]          vec_lo;
    logic [7:0]          cfg0;
    logic [7:0]          cfg1;
    logic [7:0]          cfg2;
    logic                wr0;
    logic                wr1;
    logic [7:0]          rdata;
    logic [3:0]          wait_cnt;
    logic                wait_busy;
  } rbc_regs_t;

  localparam logic [7:0] CFG0_RST = EXT_ROM ? rbc_pkg::BUS_CFG_RST_EXT
                                            : rbc_pkg::BUS_CFG_RST_INT;

  // Initial state; power-on flag is kept so a pin reset never clears it
  function automatic rbc_regs_t init_f(input logic por);
    init_f           = '0;
    init_f.state     = rbc_pkg::RBC_HOLD;
    init_f.por       = por;
    init_f.flags     = rbc_pkg::FLAGS_RST;
    init_f.nb        = rbc_pkg::NB_RST;
    init_f.ep        = rbc_pkg::PAGE_RST;
    init_f.xp        = rbc_pkg::PAGE_RST;
    init_f.yp        = rbc_pkg::PAGE_RST;
    init_f.cfg0      = CFG0_RST;
    init_f.cfg1      = rbc_pkg::STACK_PG_RST;
    init_f.cfg2      = rbc_pkg::SYS_CTRL_RST;
    init_f.rdata     = rbc_pkg::READ_MISS;
  endfunction

  rbc_regs_t          s;
  rbc_regs_t          next_s;
  rbc_pkg::rbc_mode_t mode;
  logic               settle_done;
  logic               hit0;
  logic               hit1;
  logic               hit2;
  logic [2:0]         wt;
  logic [3:0]         route;
  logic [3:0]         strobe_n;

  // ==========================================================
  // Settling counter
  rbc_settle #(
    .TICKS (SETTLE_TICKS)
  ) u_settle (
    .clk       (clk),
    .rst       (rst),
    .en        (s.state == rbc_pkg::RBC_SETTLE),
    .slow_tick (slow_tick),
    .done      (settle_done)
  );

  // ==========================================================
  // Decode
  assign mode = rbc_pkg::rbc_mode_f(s.cfg0[rbc_pkg::BSM_HI:rbc_pkg::BSM_LO],
                                    EXT_ROM);
  assign hit0 = bus_addr == rbc_pkg::ADDR_BUS_CFG;
  assign hit1 = bus_addr == rbc_pkg::ADDR_STACK_PG;
  assign hit2 = bus_addr == rbc_pkg::ADDR_SYS_CTRL;
  assign wt   = s.cfg2[rbc_pkg::WT_MSB:rbc_pkg::WT_LSB];

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    case (s.state)
      rbc_pkg::RBC_HOLD: begin
        next_s.state = s.por ? rbc_pkg::RBC_SETTLE
                             : rbc_pkg::RBC_VEC0;
      end
      rbc_pkg::RBC_SETTLE: begin
        if (settle_done) begin
          next_s.state = rbc_pkg::RBC_VEC0;
          next_s.por   = 1'b0;
        end
      end
      rbc_pkg::RBC_VEC0: begin
        next_s.state = rbc_pkg::RBC_VEC1;
      end
      rbc_pkg::RBC_VEC1: begin
        next_s.vec_lo = fetch_data;
        next_s.state  = rbc_pkg::RBC_VLOAD;
      end
      rbc_pkg::RBC_VLOAD: begin
        next_s.pc    = {fetch_data, s.vec_lo};
        next_s.cb    = rbc_pkg::NB_RST;
        next_s.state = rbc_pkg::RBC_RUN;
      end
      rbc_pkg::RBC_RUN: begin
        next_s.state = rbc_pkg::RBC_RUN;
      end
      default: begin
        next_s.state = rbc_pkg::RBC_HOLD;
      end
    endcase

    // Register writes and reads use ordinary memory cycles
    if (bus_wr && hit0) begin
      next_s.cfg0 = bus_wdata;
      next_s.wr0  = 1'b1;
    end
    if (bus_wr && hit1) begin
      next_s.cfg1 = bus_wdata;
      next_s.wr1  = 1'b1;
    end
    if (bus_wr && hit2) begin
      next_s.cfg2 = bus_wdata;
    end
    if (bus_rd) begin
      next_s.rdata = hit0 ? s.cfg0 :
                     hit1 ? s.cfg1 :
                     hit2 ? s.cfg2 : rbc_pkg::READ_MISS;
    end

    // Wait states: counted in half CPU clock ticks after T3
    if (s.wait_busy) begin
      if (half_tick) begin
        next_s.wait_cnt = s.wait_cnt - 4'h1;
        if (s.wait_cnt == 4'h1) begin
          next_s.wait_busy = 1'b0;
        end
      end
    end else if (t3_end && ext_access && (wt != 3'h0)
                 && s.cfg2[rbc_pkg::CLK_SEL]) begin
      next_s.wait_cnt  = {wt, 1'b0};
      next_s.wait_busy = 1'b1;
    end

    // Pin reset overrides everything; RAM is not touched here
    if (!reset_n) begin
      next_s = init_f(s.por);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= init_f(1'b1);
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Pin routing
  assign route    = (mode == rbc_pkg::RBC_SINGLE) ? 4'h0
                    : s.cfg0[rbc_pkg::CE_MSB:rbc_pkg::CE_LSB];
  // 512K strobes come from the bus unit's own decoder, idle here
  assign strobe_n = ~(((mode == rbc_pkg::RBC_K64) && ext_access
                       && (bus_addr[23:16] == 8'h00))
                      ? rbc_pkg::rbc_strobe_f(bus_addr[15:0],
                          s.cfg0[rbc_pkg::CES_HI:rbc_pkg::CES_LO])
                      : 4'h0);

  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign strobe_pin[i] = route[i] ? strobe_n[i] : port_r3[i];
  end

  assign bus_release_request_n = s.cfg2[rbc_pkg::REL_EN]
                                 ? shared_input_pin : 1'b1;
  assign shared_output_pin     = s.cfg2[rbc_pkg::REL_EN]
                                 ? release_ack_n : port_r51;

  // ==========================================================
  // Outputs
  assign bus_hit          = hit0 || hit1 || hit2;
  assign bus_rdata        = s.rdata;
  assign cpu_hold         = s.state != rbc_pkg::RBC_RUN;
  assign cpu_run          = s.state == rbc_pkg::RBC_RUN;
  assign fetch_req        = (s.state == rbc_pkg::RBC_VEC0)
                            || (s.state == rbc_pkg::RBC_VEC1);
  assign fetch_addr       = (s.state == rbc_pkg::RBC_VEC1)
                            ? rbc_pkg::VEC_HI_ADDR
                            : rbc_pkg::VEC_LO_ADDR;
  assign pc               = s.pc;
  assign cpu_flags        = s.flags;
  assign new_code_bank    = s.nb;
  assign code_bank        = s.cb;
  assign expand_page      = s.ep;
  assign expand_page_x    = s.xp;
  assign expand_page_y    = s.yp;
  assign bus_mode         = mode;
  assign stack_page       = ((mode == rbc_pkg::RBC_MIN512)
                             || (mode == rbc_pkg::RBC_MAX512))
                            ? s.cfg1 : 8'h00;
  assign bus_wait         = s.wait_busy;
  assign cpu_clock_select = s.cfg2[rbc_pkg::CLK_SEL];
  assign fast_osc_on      = s.cfg2[rbc_pkg::OSC_ON];
  assign voltage_mode     = s.cfg2[rbc_pkg::VDC_HI:rbc_pkg::VDC_LO];
  assign int_blocked      = !(s.wr0 && s.wr1);

  // ==========================================================
  // Assertions
  default clocking dflt_clk @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence vec_lo_s;
    fetch_req && (fetch_addr == rbc_pkg::VEC_LO_ADDR);
  endsequence
  sequence vec_hi_s;
    fetch_req && (fetch_addr == rbc_pkg::VEC_HI_ADDR);
  endsequence

  hold_in_reset_a: assert property (
    !reset_n |=> (s.state == rbc_pkg::RBC_HOLD) && cpu_hold)
    else $error("cpu not held while reset pin low");
  vec_fetch_a: assert property (
    (s.state == rbc_pkg::RBC_VEC0) |-> vec_lo_s ##1 vec_hi_s ##2 cpu_run)
    else $error("vector fetch order wrong");
  settle_gate_a: assert property (
    (s.state == rbc_pkg::RBC_SETTLE) && !settle_done && reset_n
    |=> !fetch_req)
    else $error("vector fetch before oscillator settled");
  flags_reset_a: assert property (
    !reset_n |=> cpu_flags == rbc_pkg::FLAGS_RST)
    else $error("flags not at reset value");
  pages_reset_a: assert property (
    !reset_n |=> (new_code_bank == rbc_pkg::NB_RST)
    && (expand_page == 8'h00) && (expand_page_x == 8'h00)
    && (expand_page_y == 8'h00))
    else $error("bank or page registers not reset");
  cb_load_a: assert property (
    $rose(cpu_run) |-> (code_bank == rbc_pkg::NB_RST)
    && (pc[15:8] == $past(fetch_data)))
    else $error("vector or code bank not loaded");
  strobe_port_a: assert property (
    (bus_mode == rbc_pkg::RBC_SINGLE) |-> (strobe_pin == port_r3))
    else $error("strobe routed in single chip mode");
  stack_page_a: assert property (
    (bus_mode == rbc_pkg::RBC_K64) || (bus_mode == rbc_pkg::RBC_SINGLE)
    |-> stack_page == 8'h00)
    else $error("stack page nonzero outside 512K");
  release_off_a: assert property (
    !s.cfg2[rbc_pkg::REL_EN] |-> bus_release_request_n
    && (shared_output_pin == port_r51))
    else $error("release pins active while disabled");
  int_unblock_a: assert property (
    $fell(int_blocked) |-> $past(bus_wr && (hit0 || hit1)))
    else $error("interrupts unblocked without config write");
  wait_slow_a: assert property (
    !bus_wait && !cpu_clock_select |=> !bus_wait)
    else $error("wait inserted on slow clock");

endmodule

// ===== design/rbc_settle.sv
// Oscillator settling counter, counts slow oscillator periods
// Assumes slow_tick is a one-cycle pulse per slow oscillator period
`timescale 1ns/1ps
module rbc_settle #(
  parameter int unsigned TICKS = rbc_pkg::SETTLE_PERIODS
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic slow_tick,
  output logic      done
);

  localparam int W = $clog2(TICKS + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
  } rbc_settle_t;

  rbc_settle_t s;
  rbc_settle_t next_s;

  // ==========================================================
  // Count while enabled, restart from zero whenever disabled
  always_comb begin
    next_s = s;
    if (!en) begin
      next_s.cnt = '0;
    end else if (slow_tick && (s.cnt != W'(TICKS))) begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign done = en && (s.cnt == W'(TICKS));

endmodule
